// ---- src/rx_lo_preamble_readout_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - hold bit set: freeze offset after preamble
// - hold bit clear: offset keeps updating
// - hold bit ignored in amplitude-keyed mode
// - centre word bits 23:16 at 0x09, reset 0x13
// - centre word bits 15:8 at 0x0A, reset 0xA9
// - centre word bits 7:0 at 0x0B, reset 0x9A
// - pattern length is field plus one, reset 0xF
// - pattern bits 7:0 in lower pattern register
// - pattern bits 15:8 in upper, reset zero
// - frequency error signed read-only register
// - filter output signed read-only at 0x12
module rx_lo_preamble_readout_regs (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [rx_regs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [rx_regs_pkg::DATA_W-1:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [rx_regs_pkg::DATA_W-1:0] reg_rd_data,
   input wire logic fsk_mode,
   input wire logic preamble_detected,
   input wire logic frame_restart,
   input wire logic offset_update_valid,
   input wire logic [7:0] offset_update,
   input wire logic strength_valid,
   input wire logic [7:0] signal_strength_in,
   input wire logic offset_error_valid,
   input wire logic [7:0] offset_error_in,
   input wire logic filter_valid,
   input wire logic [7:0] filter_in,
   output logic [23:0] local_osc_center_word,
   output logic [4:0] preamble_pattern_length,
   output logic [15:0] preamble_pattern_bits,
   output logic offset_held,
   output logic [7:0] applied_offset
);

   ////////////////////////////////////////////////////////////////////
   logic [7:0] hold_ctrl_r;
   logic [7:0] lo_high_r;
   logic [7:0] lo_mid_r;
   logic [7:0] lo_low_r;
   logic [3:0] len_r;
   logic [4:0] len_out_r;
   logic [7:0] pat_low_r;
   logic [7:0] pat_high_r;
   logic [7:0] signal_strength_reading;
   logic [7:0] offset_error_reading;
   logic [7:0] post_demod_filter_reading;
   logic [7:0] rd_data_r;
   logic [7:0] offset_r;
   rx_regs_pkg::hold_state_e hold_r;
   rx_regs_pkg::hold_state_e hold_nxt;

   wire wr = clk_en && reg_wr_en;
   wire wr_hold = wr && (reg_addr == rx_regs_pkg::OFFSET_HOLD_CTRL_ADDR);
   wire wr_lo_high = wr && (reg_addr == rx_regs_pkg::LO_WORD_HIGH_ADDR);
   wire wr_lo_mid = wr && (reg_addr == rx_regs_pkg::LO_WORD_MID_ADDR);
   wire wr_lo_low = wr && (reg_addr == rx_regs_pkg::LO_WORD_LOW_ADDR);
   wire wr_len = wr && (reg_addr == rx_regs_pkg::PREAMBLE_LEN_ADDR);
   wire wr_pat_low = wr && (reg_addr == rx_regs_pkg::PATTERN_LOW_ADDR);
   wire wr_pat_high = wr && (reg_addr == rx_regs_pkg::PATTERN_HIGH_ADDR);
   // one extra bit carries the plus-one without wrap at 0xf;
   // flopped apart from the field so the output needs no adder behind it
   wire [4:0] len_wr_plus_one =
      {1'b0, reg_wr_data[rx_regs_pkg::LEN_FIELD_MSB:0]} + 5'h01;
   // amplitude-keyed reception never holds
   wire hold_enable = hold_ctrl_r[rx_regs_pkg::HOLD_BIT_POS] && fsk_mode;
   // bit 7 is unimplemented and always reads zero
   wire [7:0] hold_read = {1'b0, hold_ctrl_r[6:0]};
   wire [7:0] rd_mux =
      (reg_addr == rx_regs_pkg::OFFSET_HOLD_CTRL_ADDR) ? hold_read :
      (reg_addr == rx_regs_pkg::LO_WORD_HIGH_ADDR) ? lo_high_r :
      (reg_addr == rx_regs_pkg::LO_WORD_MID_ADDR) ? lo_mid_r :
      (reg_addr == rx_regs_pkg::LO_WORD_LOW_ADDR) ? lo_low_r :
      (reg_addr == rx_regs_pkg::PREAMBLE_LEN_ADDR) ? {4'h0, len_r} :
      (reg_addr == rx_regs_pkg::PATTERN_LOW_ADDR) ? pat_low_r :
      (reg_addr == rx_regs_pkg::PATTERN_HIGH_ADDR) ? pat_high_r :
      (reg_addr == rx_regs_pkg::STRENGTH_ADDR) ? signal_strength_reading :
      (reg_addr == rx_regs_pkg::OFFSET_ERROR_ADDR) ? offset_error_reading :
      (reg_addr == rx_regs_pkg::FILTER_OUT_ADDR) ? post_demod_filter_reading :
      rx_regs_pkg::UNMAPPED_READ;

   ////////////////////////////////////////////////////////////////////
   // writable registers; reserved hold bits are stored as written
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hold_ctrl_r <= rx_regs_pkg::OFFSET_HOLD_CTRL_RST;
         lo_high_r <= rx_regs_pkg::LO_WORD_HIGH_RST;
         lo_mid_r <= rx_regs_pkg::LO_WORD_MID_RST;
         lo_low_r <= rx_regs_pkg::LO_WORD_LOW_RST;
         len_r <= rx_regs_pkg::PREAMBLE_LEN_RST;
         len_out_r <= {1'b0, rx_regs_pkg::PREAMBLE_LEN_RST} + 5'h01;
         pat_low_r <= rx_regs_pkg::PATTERN_LOW_RST;
         pat_high_r <= rx_regs_pkg::PATTERN_HIGH_RST;
      end else begin
         if (wr_hold) hold_ctrl_r <= reg_wr_data;
         if (wr_lo_high) lo_high_r <= reg_wr_data;
         if (wr_lo_mid) lo_mid_r <= reg_wr_data;
         if (wr_lo_low) lo_low_r <= reg_wr_data;
         if (wr_len) len_r <= reg_wr_data[rx_regs_pkg::LEN_FIELD_MSB:0];
         if (wr_len) len_out_r <= len_wr_plus_one;
         if (wr_pat_low) pat_low_r <= reg_wr_data;
         if (wr_pat_high) pat_high_r <= reg_wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // readouts follow hardware only; bus writes never reach them
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         signal_strength_reading <= rx_regs_pkg::READOUT_RST;
         offset_error_reading <= rx_regs_pkg::READOUT_RST;
         post_demod_filter_reading <= rx_regs_pkg::READOUT_RST;
         rd_data_r <= rx_regs_pkg::UNMAPPED_READ;
      end else if (clk_en) begin
         if (strength_valid) signal_strength_reading <= signal_strength_in;
         if (offset_error_valid) offset_error_reading <= offset_error_in;
         if (filter_valid) post_demod_filter_reading <= filter_in;
         if (reg_rd_en) rd_data_r <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hold lasts until the frame restarts or hold_enable drops; a restart in the detect cycle wins
   always_comb begin
      hold_nxt = hold_r;
      case (hold_r)
         rx_regs_pkg::TRACKING: begin
            if (hold_enable && preamble_detected && !frame_restart) begin
               hold_nxt = rx_regs_pkg::HOLDING;
            end
         end
         rx_regs_pkg::HOLDING: begin
            if (!hold_enable || frame_restart) begin
               hold_nxt = rx_regs_pkg::TRACKING;
            end
         end
         default: hold_nxt = rx_regs_pkg::TRACKING;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hold_r <= rx_regs_pkg::TRACKING;
         offset_r <= 8'h00;
      end else if (clk_en) begin
         hold_r <= hold_nxt;
         if (offset_update_valid && hold_r == rx_regs_pkg::TRACKING) begin
            offset_r <= offset_update;
         end
      end
   end

   assign reg_rd_data = rd_data_r;
   assign local_osc_center_word = {lo_high_r, lo_mid_r, lo_low_r};
   assign preamble_pattern_length = len_out_r;
   assign preamble_pattern_bits = {pat_high_r, pat_low_r};
   assign offset_held = (hold_r == rx_regs_pkg::HOLDING);
   assign applied_offset = offset_r;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   hold_entry_a: assert property (clk_en && hold_enable && preamble_detected
      && !frame_restart |=> offset_held) else $error("hold not entered after preamble");
   offset_frozen_a: assert property (clk_en && offset_held |=>
      $stable(applied_offset)) else $error("offset changed while held");
   no_hold_clear_a: assert property (clk_en && !hold_ctrl_r[6] |=>
      !offset_held) else $error("held with hold bit clear");
   offset_track_a: assert property (clk_en && offset_update_valid && !offset_held
      |=> applied_offset == $past(offset_update)) else $error("offset not applied");
   ask_no_hold_a: assert property (clk_en && !fsk_mode |=> !offset_held)
      else $error("held in amplitude mode");
   lo_high_wr_a: assert property (wr_lo_high |=>
      local_osc_center_word[23:16] == $past(reg_wr_data)) else $error("high byte lost");
   lo_mid_wr_a: assert property (wr_lo_mid |=>
      local_osc_center_word[15:8] == $past(reg_wr_data)) else $error("mid byte lost");
   lo_low_wr_a: assert property (wr_lo_low |=>
      local_osc_center_word[7:0] == $past(reg_wr_data)) else $error("low byte lost");
   len_plus_one_a: assert property (wr_len |=> preamble_pattern_length ==
      {1'b0, $past(reg_wr_data[3:0])} + 5'h01) else $error("length not field plus one");
   pattern_wr_a: assert property (wr_pat_low ##1 wr_pat_high |=>
      preamble_pattern_bits == {$past(reg_wr_data), $past(reg_wr_data, 2)})
      else $error("pattern bytes misplaced");
   pat_low_wr_a: assert property (wr_pat_low |=>
      preamble_pattern_bits[7:0] == $past(reg_wr_data)) else $error("low pattern byte lost");
   pat_high_wr_a: assert property (wr_pat_high |=>
      preamble_pattern_bits[15:8] == $past(reg_wr_data)) else $error("high pattern byte lost");
   strength_cap_a: assert property (clk_en && strength_valid |=>
      signal_strength_reading == $past(signal_strength_in)) else $error("strength lost");
   error_read_a: assert property (clk_en && reg_rd_en && !offset_error_valid
      && reg_addr == rx_regs_pkg::OFFSET_ERROR_ADDR |=>
      reg_rd_data == $past(offset_error_reading)) else $error("error readout wrong");
   filter_cap_a: assert property (clk_en && filter_valid |=>
      post_demod_filter_reading == $past(filter_in)) else $error("filter lost");
   ro_write_a: assert property (wr && !strength_valid && !offset_error_valid
      && !filter_valid |=> $stable(signal_strength_reading)
      && $stable(offset_error_reading) && $stable(post_demod_filter_reading))
      else $error("readout changed by write");
   stall_freeze_a: assert property (!clk_en |=> $stable(local_osc_center_word)
      && $stable(preamble_pattern_bits) && $stable(preamble_pattern_length)
      && $stable(offset_held) && $stable(applied_offset) && $stable(reg_rd_data))
      else $error("state moved while clock enable low");
   hold_read_a: assert property (clk_en && reg_rd_en
      && reg_addr == rx_regs_pkg::OFFSET_HOLD_CTRL_ADDR |=> !reg_rd_data[7]
      && reg_rd_data[rx_regs_pkg::HOLD_BIT_POS]
      == $past(hold_ctrl_r[rx_regs_pkg::HOLD_BIT_POS]))
      else $error("hold control readback wrong");
   // read data must stand until the next taken read
   rd_hold_a: assert property (!(clk_en && reg_rd_en) |=> $stable(reg_rd_data))
      else $error("read data moved without a read");

   hold_seen_c: cover property (offset_held ##1 frame_restart ##1 !offset_held);
   read_back_c: cover property (wr_lo_mid ##1 clk_en && reg_rd_en);
   ask_detect_c: cover property (!fsk_mode && preamble_detected && hold_ctrl_r[6]);
   offset_track_c: cover property (clk_en && offset_update_valid && !offset_held);
   stall_write_c: cover property (!clk_en && reg_wr_en);
endmodule

// ---- shared/rx_regs_pkg.sv ----
package rx_regs_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [6:0] OFFSET_HOLD_CTRL_ADDR = 7'h08;
   localparam logic [6:0] LO_WORD_HIGH_ADDR = 7'h09;
   localparam logic [6:0] LO_WORD_MID_ADDR = 7'h0a;
   localparam logic [6:0] LO_WORD_LOW_ADDR = 7'h0b;
   localparam logic [6:0] PREAMBLE_LEN_ADDR = 7'h0c;
   localparam logic [6:0] PATTERN_LOW_ADDR = 7'h0d;
   localparam logic [6:0] PATTERN_HIGH_ADDR = 7'h0e;
   localparam logic [6:0] STRENGTH_ADDR = 7'h10;
   localparam logic [6:0] OFFSET_ERROR_ADDR = 7'h11;
   localparam logic [6:0] FILTER_OUT_ADDR = 7'h12;
   // field positions
   localparam int HOLD_BIT_POS = 6;
   localparam int RESERVED_MSB = 5;
   localparam int LEN_FIELD_MSB = 3;
   // reset values
   localparam logic [7:0] OFFSET_HOLD_CTRL_RST = 8'h00;
   localparam logic [7:0] LO_WORD_HIGH_RST = 8'h13;
   localparam logic [7:0] LO_WORD_MID_RST = 8'ha9;
   localparam logic [7:0] LO_WORD_LOW_RST = 8'h9a;
   localparam logic [3:0] PREAMBLE_LEN_RST = 4'hf;
   localparam logic [7:0] PATTERN_LOW_RST = 8'h00;
   localparam logic [7:0] PATTERN_HIGH_RST = 8'h00;
   localparam logic [7:0] READOUT_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // hold state of the offset loop
   typedef enum logic {TRACKING, HOLDING} hold_state_e;
endpackage

// ---- test/host_model.sv ----
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   output logic [6:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en
);
   initial begin
      reg_addr = 7'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // one strobe per access; released lines show no stale value
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      reg_wr_data = d;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, resetn, clk_en, fsk_mode, preamble_detected, frame_restart, upd_v, held;
   logic [7:0] upd, rd_data, last_off, applied, v [6];
   logic [2:0] ro_v;
   logic [7:0] ro_d [3];
   logic [23:0] center;
   logic [4:0] len;
   logic [15:0] pattern, rng;
   logic [6:0] addr;
   logic wr_en, rd_en, rd_taken;
   logic [7:0] wr_data, exp_q [$];
   int mismatches, num_checks, cycles;
   localparam logic [6:0] rst_a [11] = '{7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e,
      7'h10, 7'h11, 7'h12, 7'h0f};
   localparam logic [7:0] rst_v [11] = '{8'h00, 8'h13, 8'ha9, 8'h9a, 8'h0f, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};
   rx_lo_preamble_readout_regs dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
      .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data), .reg_rd_en(rd_en),
      .reg_rd_data(rd_data), .fsk_mode(fsk_mode), .preamble_detected(preamble_detected),
      .frame_restart(frame_restart), .offset_update_valid(upd_v), .offset_update(upd),
      .strength_valid(ro_v[0]), .signal_strength_in(ro_d[0]), .offset_error_valid(ro_v[1]),
      .offset_error_in(ro_d[1]), .filter_valid(ro_v[2]), .filter_in(ro_d[2]),
      .local_osc_center_word(center), .preamble_pattern_length(len),
      .preamble_pattern_bits(pattern), .offset_held(held), .applied_offset(applied));
   host_model host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr_en(wr_en),
      .reg_wr_data(wr_data), .reg_rd_en(rd_en));
   ////////////////////////////////////////////////////////////////////////////////
   always #5 ref_clk = ~ref_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input string n, input logic [23:0] e, input logic [23:0] s);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // read data lands one edge after the taken strobe
   always @(posedge ref_clk) rd_taken <= resetn && clk_en && rd_en;
   always @(negedge ref_clk) begin
      if (rd_taken) check("rd_data", exp_q.pop_front(), rd_data);
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 0; resetn = 0; clk_en = 1; fsk_mode = 0; preamble_detected = 0;
      frame_restart = 0; upd_v = 0; upd = 8'h00; ro_v = 3'h0; last_off = 8'h00;
      ro_d = '{8'h00, 8'h00, 8'h00};
      rng = 16'hf2fb; // seed 62203
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk) resetn = 1;
      foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
      check("center", 24'h13_a99a, center);
      check("len", 24'h00_0010, 24'(len));
      for (int i = 0; i < 6; i++) begin
         rng = lfsr(rng);
         v[i] = rng[7:0];
         host.access(1'b1, 7'(7'h09 + i), v[i]);
         rd(7'(7'h09 + i), i == 3 ? {4'h0, v[i][3:0]} : v[i]);
      end
      check("center", {v[0], v[1], v[2]}, center);
      check("len", 24'(v[3][3:0]) + 24'h00_0001, 24'(len));
      check("pattern", 24'({v[5], v[4]}), 24'(pattern));
      host.access(1'b1, 7'h0c, 8'h00);
      check("len", 24'h00_0001, 24'(len));
      // stalled clock enable must drop the write
      clk_en = 0;
      host.access(1'b1, 7'h09, ~v[0]);
      clk_en = 1;
      check("center", {v[0], v[1], v[2]}, center);
      for (int k = 0; k < 3; k++) begin
         rng = lfsr(rng);
         @(negedge ref_clk) ro_d[k] = rng[7:0];
         ro_v[k] = 1;
         @(negedge ref_clk) ro_v[k] = 0;
         host.access(1'b1, 7'(7'h10 + k), ~rng[7:0]);
         rd(7'(7'h10 + k), rng[7:0]);
      end
      for (int j = 0; j < 3; j++) begin
         host.access(1'b1, 7'h08, j == 1 ? 8'h00 : 8'h40);
         fsk_mode = (j != 2);
         @(negedge ref_clk) preamble_detected = 1;
         @(negedge ref_clk) preamble_detected = 0;
         check("held", 24'(j == 0), 24'(held));
         rng = lfsr(rng);
         upd = rng[7:0];
         upd_v = 1;
         if (j != 0) last_off = upd;
         @(negedge ref_clk) upd_v = 0;
         check("offset", 24'(last_off), 24'(applied));
         frame_restart = 1;
         @(negedge ref_clk) frame_restart = 0;
         check("held", 24'h00_0000, 24'(held));
      end
      repeat (2) @(negedge ref_clk);
      report_and_stop();
   end
endmodule
